// ==== bench/testbench.sv ====
// Self-checking bench for the crypto engine control register block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import crypto_ctrl_pkg::*;
    logic              clk_i = 1'b0;
    logic              rst_i = 1'b1;
    logic [11:0]       reg_addr_i = 12'h000;
    logic              reg_wr_i = 1'b0;
    logic              reg_rd_i = 1'b0;
    logic [31:0]       reg_wdata_i = 32'h0000_0000;
    logic              done_i = 1'b0;
    logic [3:0][127:0] bank = {{32{4'h4}}, {32{4'h3}}, {32{4'h2}}, {32{4'h1}}};
    logic [127:0]      outb = {32{4'h8}};
    logic [127:0]      res = {32{4'hc}};
    logic [127:0]      kin, kout;
    logic [31:0]       rdata, fwd;
    cipher_cfg_t       ccfg;
    bank_cfg_t         bcfg;
    hash_cfg_t         hcfg;
    logic              acc = 1'b0;
    logic              start, busy, iclr, kclr, fclr, fwr;
    logic [15:0]       count;
    int                num_errors = 0;
    int                compares = 0;

    crypto_engine_control DUT (.clk_i(clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i),
        .reg_rdata_o(rdata), .input_bank_i(bank), .output_bank_i(outb),
        .kernel_result_i(res), .kernel_done_i(done_i), .bank_access_i(acc),
        .hw_mask_i(32'h0000_0000), .hash_fifo_rdata_i(32'h0000_0000),
        .kernel_input_o(kin), .output_data_o(kout), .cipher_cfg_o(ccfg), .bank_cfg_o(bcfg),
        .hash_cfg_o(hcfg), .start_o(start), .busy_o(busy), .calc_count_o(count),
        .input_bank_clear_o(iclr), .key_bank_clear_o(kclr), .full_flush_o(fclr),
        .hash_fifo_wr_o(fwr), .hash_fifo_wdata_o(fwd));

    initial forever #50 clk_i = ~clk_i;

    // ------------------------------------------------------------
    // Access and checking tasks
    // ------------------------------------------------------------
    task automatic check(input logic [127:0] seen, input logic [127:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_i);
        reg_wr_i <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
        @(posedge clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_i);
        reg_rd_i <= 1'b0;
        #1;
        check(rdata, exp, what);
    endtask
    // Start an operation, then finish it with one done pulse
    task automatic run(input logic [31:0] v, input logic [15:0] expc);
        wr(OFS_CTRL_PRI, v | 32'h1);
        check(start, 1'b1, "start pulse");
        check(busy, 1'b1, "busy set");
        check(count, expc, "calc count");
        wr(OFS_CTRL_PRI, v | 32'h1);
        check(count, expc, "count while busy");
        @(posedge clk_i);
        done_i <= 1'b1;
        @(posedge clk_i);
        done_i <= 1'b0;
        @(posedge clk_i);
        #1;
        check(busy, 1'b0, "busy cleared");
    endtask
    task automatic stop_test;
        $display("comparisons %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0]  v;
        logic [127:0] ei, eo;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(OFS_HASH_CTRL, RST_HASH_CTRL, "hash reset");
        rd(12'hd20, 32'h0, "unmapped read");
        $display("reset test done");
        v = 32'(5'h0a) << P_KBASE | 32'h7 << P_AESEN | 32'h2 << P_KLEN | 32'h2 | 32'h1 << P_TKEY;
        wr(OFS_CTRL_PRI, v | 32'(OP_TDES) << P_OP | 32'h1 << P_PRNG);
        rd(OFS_CTRL_PRI, (v | 32'(OP_TDES) << P_OP | 32'h1 << P_PRNG) & MASK_CTRL_PRI, "ctrl");
        check(ccfg.input_key_base, 5'h0a, "key base");
        check({ccfg.field_mult_enable, ccfg.des_enable, ccfg.aes_enable}, 3'h7, "enables");
        check({ccfg.aes_key_length, ccfg.cipher_direction}, 3'h5, "keylen dir");
        check(ccfg.random_gen_enable, 1'b1, "prng enable");
        check(ccfg.operation_select, OP_TDES, "op");
        wr(OFS_CTRL_PRI, 32'h7 << P_OP);
        check(ccfg.operation_select, OP_AES, "reserved op");
        check(start, 1'b0, "zero start");
        run(32'h0, 16'h1);
        wr(OFS_HASH_CTRL, 32'h1);
        run(32'(OP_SHA) << P_OP, 16'h1);
        wr(OFS_HASH_CTRL, 32'h1 | 32'h1 << H_CNT);
        run(32'(OP_SHA) << P_OP, 16'h2);
        $display("start test done");
        for (int c = 0; c < 16; c++) begin
            wr(OFS_CTRL_PRI, 32'(c) << P_INPUT_MUX_SELECT | 32'(c & 7) << P_OSEL);
            @(posedge clk_i);
            #1;
            ei = c < 4 ? bank[c] : c < 8 ? bank[c-4] ^ outb : c == 8 ? outb : bank[0];
            eo = (c & 7) inside {[1:4]} ? res ^ bank[(c & 7) - 1] : res;
            check(kin, ei, "kernel input");
            check(kout, eo, "output data");
        end
        for (int i = 0; i < 3; i++) begin
            wr(OFS_CTRL_SEC, 32'h1 << i);
            check({iclr, kclr, fclr}, 3'h1 << i, "flush pulses");
        end
        rd(OFS_CTRL_SEC, 32'h0, "flush bits");
        wr(OFS_SW_MASK, 32'h1234_5678);
        wr(OFS_CTRL_SEC, 32'h0040_0778);
        check(bcfg, {6'h3f, 32'h1234_5678}, "bank cfg");
        wr(OFS_HASH_FIFO, 32'h1122_3344);
        check({fwr, fwd}, 33'h1_4433_2211, "fifo swap");
        wr(OFS_SEED, 32'h10);
        @(posedge clk_i);
        acc <= 1'b1;
        @(posedge clk_i);
        acc <= 1'b0;
        rd(OFS_SEED, 32'h11, "seed step");
        rd(OFS_SEED, 32'h12, "seed read step");
        wr(OFS_HASH_CTRL, 32'hb00f);
        check(hcfg, 14'h3d00, "hash cfg");
        wr(OFS_HASH_CTRL, 32'h4003);
        check(hcfg, 14'h2200, "hash stop");
        $display("mux, flush and config test done");
        stop_test;
    end

    initial begin
        repeat (5000) @(posedge clk_i);
        num_errors++;
        stop_test;
    end
endmodule // testbench
`default_nettype wire

// ==== hw/crypto_ctrl_pkg.sv ====
// Constants, field layouts and types for the crypto engine control block
//
// Summary of operation
// RULE1 - Five-bit field picks the key bank base index for the kernel input key.
// RULE2 - One bit enables the internal random generator, only when it is built in.
// RULE3 - Three bits enable the field multiply, DES and AES kernels.
// RULE4 - Two-bit field picks when results reach the output bank: end, start, trigger, never.
// RULE5 - Output bank gets raw result, or result XOR input bank 0..3; codes 5..7 raw.
// RULE6 - Kernel input is bank 0..3, bank XOR output, output alone, else bank 0.
// RULE7 - A select naming an absent input bank uses input bank 0 instead.
// RULE8 - Three-bit operation code; reserved codes use first available; one bit picks TDES keys.
// RULE9 - Key size 00 is AES-128, 10 is AES-256, 11 behaves as AES-128.
// RULE10 - Direction bit: clear encrypts, set decrypts, for AES and DES.
// RULE11 - Writing one to the start bit starts an operation; writing zero does nothing. The code ignores a start written while busy.
// RULE12 - Byte-order bit presents bank read and write data normal or byte-swapped.
// RULE13 - Result-location bit sends results to output bank or key bank at a base.
// RULE14 - Masking enable, mask source select, and seed step on access or also seed read.
// RULE15 - Increment carry-in is one, or the overflow of the previous increment.
// RULE16 - Write-side controls enable flush-write, XOR-on-write and increment-on-write.
// RULE17 - Writing one starts input bank, key bank or full flush; zero does nothing.
// RULE18 - Two ten-bit dummy-cycle settings, one for AES and one for DES.
// RULE19 - Hash initialises automatically unless no-auto-init is set; reload bit enables reload.
// RULE20 - Hash operations bump the calculation counter only when count enable is set.
// RULE21 - Hash size 224/256/384/512; a 256-only build maps 10 to 224, 11 to 256.
// RULE22 - Hash enable, normal or automatic mode, and a stop bit that ends automatic mode.
// RULE23 - Busy stays asserted from calculation start until the calculation finishes. The code also clears busy on a full flush.
// RULE24 - Sixteen-bit calculation counter increments on each calculation start. The code does not count hash starts while count enable is clear.
// RULE25 - Start and flush bits read back as zero once the command is accepted.
package crypto_ctrl_pkg;

    localparam int          BLOCK_W        = 128;
    localparam int          ADDR_W         = 12;

    // Register offsets
    localparam logic [11:0] OFS_CTRL_PRI   = 12'hd00;
    localparam logic [11:0] OFS_CTRL_SEC   = 12'hd04;
    localparam logic [11:0] OFS_DUMMY      = 12'hd08;
    localparam logic [11:0] OFS_SW_MASK    = 12'hd0c;
    localparam logic [11:0] OFS_SEED       = 12'hd10;
    localparam logic [11:0] OFS_HASH_CTRL  = 12'hd14;
    localparam logic [11:0] OFS_HASH_FIFO  = 12'hd18;
    localparam logic [11:0] OFS_BUILD_CFG  = 12'hd1c;

    // Writable bits and reset values
    localparam logic [31:0] MASK_CTRL_PRI  = 32'h03ff_fffe;
    localparam logic [31:0] MASK_CTRL_SEC  = 32'h00ff_f778;
    localparam logic [31:0] MASK_DUMMY     = 32'h03ff_03ff;
    localparam logic [31:0] MASK_HASH_CTRL = 32'h0000_bfff;
    localparam logic [31:0] RST_HASH_CTRL  = 32'h0000_0f00;

    // Primary control fields
    localparam int P_START = 0;
    localparam int P_DIR   = 1;
    localparam int P_KLEN  = 2;
    localparam int P_OP    = 4;
    localparam int P_INPUT_MUX_SELECT = 7;
    localparam int P_OSEL  = 11;
    localparam int P_OUPD  = 14;
    localparam int P_AESEN = 16;
    localparam int P_DESEN = 17;
    localparam int P_GFEN  = 18;
    localparam int P_PRNG  = 19;
    localparam int P_KBASE = 20;
    localparam int P_TKEY  = 25;

    // Secondary control fields
    localparam int S_FLUSH = 0;
    localparam int S_KFL   = 1;
    localparam int S_DFL   = 2;
    localparam int S_INCREMENT_ON_WRITE  = 3;
    localparam int S_XOR_ON_WRITE = 4;
    localparam int S_FLWR  = 5;
    localparam int S_CIN   = 6;
    localparam int S_MEN   = 8;
    localparam int S_MSTEP = 9;
    localparam int S_MSW   = 10;
    localparam int S_RBASE = 16;
    localparam int S_RKEY  = 21;
    localparam int S_BSWAP = 22;

    // Hash control fields
    localparam int H_EN    = 0;
    localparam int H_AUTO  = 1;
    localparam int H_SIZE  = 2;
    localparam int H_LOW   = 4;
    localparam int H_HIGH  = 8;
    localparam int H_CNT   = 12;
    localparam int H_RLD   = 13;
    localparam int H_STOP  = 14;
    localparam int H_NOINI = 15;

    // Operation codes
    localparam logic [2:0] OP_AES  = 3'h0;
    localparam logic [2:0] OP_DES  = 3'h1;
    localparam logic [2:0] OP_TDES = 3'h2;
    localparam logic [2:0] OP_GF   = 3'h3;
    localparam logic [2:0] OP_SHA  = 3'h4;
    localparam logic [2:0] OP_CMAC = 3'h5;

    typedef struct packed {
        logic [2:0] operation_select;
        logic       triple_key_count_sel;
        logic [4:0] input_key_base;
        logic [1:0] aes_key_length;
        logic       cipher_direction;
        logic       aes_enable;
        logic       des_enable;
        logic       field_mult_enable;
        logic       random_gen_enable;
        logic [1:0] output_update_timing;
        logic       result_to_key;
        logic [4:0] result_key_base;
        logic [9:0] aes_dummy_setting;
        logic [9:0] des_dummy_setting;
    } cipher_cfg_t;

    typedef struct packed {
        logic       flush_write_mode;
        logic       xor_on_write;
        logic       increment_on_write;
        logic       increment_carry_select;
        logic       bank_byte_swap;
        logic       register_mask_enable;
        logic [31:0] mask_value;
    } bank_cfg_t;

    typedef struct packed {
        logic       hash_unit_enable;
        logic       hash_auto_select;
        logic [1:0] hash_length_sel;
        logic       hash_auto_init;
        logic       hash_value_reload;
        logic [3:0] fifo_low_limit;
        logic [3:0] fifo_high_limit;
    } hash_cfg_t;

    typedef struct packed {
        logic [31:0]        ctrl;
        logic [31:0]        ctrl2;
        logic [31:0]        dummy;
        logic [31:0]        sw_mask;
        logic [31:0]        seed;
        logic [31:0]        hash;
        logic               busy;
        logic [15:0]        count;
        logic               start;
        logic               flush_in;
        logic               flush_key;
        logic               flush_all;
        logic               fifo_wr;
        logic [31:0]        fifo_wdata;
        logic [31:0]        rdata;
        logic [BLOCK_W-1:0] kin;
        logic [BLOCK_W-1:0] kout;
    } state_t;

endpackage

// ==== hw/crypto_engine_control.sv ====
// Control and configuration register set of the cipher and hash engine
`timescale 1ns/1ps
`default_nettype none

module crypto_engine_control #(
    parameter int NUM_INPUT_BANKS = 4,
    parameter bit HAS_AES         = 1'b1,
    parameter bit HAS_DES         = 1'b1,
    parameter bit HAS_GFMUL       = 1'b1,
    parameter bit HAS_SHA         = 1'b1,
    parameter bit HAS_CMAC        = 1'b1,
    parameter bit HAS_PRNG        = 1'b1,
    parameter bit SHA256_ONLY     = 1'b0
) (
    input  wire logic                                     clk_i,
    input  wire logic                                     rst_i,
    input  wire logic [crypto_ctrl_pkg::ADDR_W-1:0]       reg_addr_i,
    input  wire logic                                     reg_wr_i,
    input  wire logic                                     reg_rd_i,
    input  wire logic [31:0]                              reg_wdata_i,
    output logic      [31:0]                              reg_rdata_o,
    input  wire logic [NUM_INPUT_BANKS-1:0][crypto_ctrl_pkg::BLOCK_W-1:0] input_bank_i,
    input  wire logic [crypto_ctrl_pkg::BLOCK_W-1:0]      output_bank_i,
    input  wire logic [crypto_ctrl_pkg::BLOCK_W-1:0]      kernel_result_i,
    input  wire logic                                     kernel_done_i,
    input  wire logic                                     bank_access_i,
    input  wire logic [31:0]                              hw_mask_i,
    input  wire logic [31:0]                              hash_fifo_rdata_i,
    output logic      [crypto_ctrl_pkg::BLOCK_W-1:0]      kernel_input_o,
    output logic      [crypto_ctrl_pkg::BLOCK_W-1:0]      output_data_o,
    output crypto_ctrl_pkg::cipher_cfg_t                  cipher_cfg_o,
    output crypto_ctrl_pkg::bank_cfg_t                    bank_cfg_o,
    output crypto_ctrl_pkg::hash_cfg_t                    hash_cfg_o,
    output logic                                          start_o,
    output logic                                          busy_o,
    output logic      [15:0]                              calc_count_o,
    output logic                                          input_bank_clear_o,
    output logic                                          key_bank_clear_o,
    output logic                                          full_flush_o,
    output logic                                          hash_fifo_wr_o,
    output logic      [31:0]                              hash_fifo_wdata_o
);
    import crypto_ctrl_pkg::*;

    state_t q;
    state_t d;

    logic       wr_pri;
    logic       wr_sec;
    logic       start_ok;
    logic       count_ok;
    logic [2:0] op_eff;
    logic [2:0] op_wr;
    logic [31:0] build_cfg;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] swap32(input logic [31:0] v, input logic en);
        swap32 = en ? {v[7:0], v[15:8], v[23:16], v[31:24]} : v;
    endfunction

    // RULE7 - absent bank to zero
    function automatic logic [1:0] bank_idx(input logic [1:0] idx);
        bank_idx = (32'(idx) < NUM_INPUT_BANKS) ? idx : 2'h0;
    endfunction

    // RULE8 - first available operation
    function automatic logic [2:0] first_op();
        if (HAS_AES) begin
            first_op = OP_AES;
        end else if (HAS_DES) begin
            first_op = OP_DES;
        end else if (HAS_GFMUL) begin
            first_op = OP_GF;
        end else if (HAS_SHA) begin
            first_op = OP_SHA;
        end else begin
            first_op = OP_CMAC;
        end
    endfunction

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    assign wr_pri   = reg_wr_i && (reg_addr_i == OFS_CTRL_PRI);
    assign wr_sec   = reg_wr_i && (reg_addr_i == OFS_CTRL_SEC);
    // Start while busy is ignored so the counter tracks real calculations
    assign start_ok = wr_pri && reg_wdata_i[P_START] && !q.busy;
    // RULE20 - hash gated counting
    assign count_ok = start_ok && ((op_wr != OP_SHA) || q.hash[H_CNT]);

    // RULE8 - operation select
    always_comb begin
        op_eff = q.ctrl[P_OP +: 3];
        if (op_eff > OP_CMAC) begin
            op_eff = first_op();
        end
    end

    // RULE8 - op of a start write
    always_comb begin
        op_wr = reg_wdata_i[P_OP +: 3];
        if (op_wr > OP_CMAC) begin
            op_wr = first_op();
        end
    end

    assign build_cfg = {7'h00, SHA256_ONLY, 6'h00,
                        2'(NUM_INPUT_BANKS - 1), 1'b1, 3'h0, 1'b0, 1'b0,
                        HAS_PRNG, HAS_GFMUL, HAS_CMAC, 1'b0, HAS_SHA, HAS_DES,
                        HAS_AES, 3'h0};

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        d            = q;
        d.start      = 1'b0;
        d.flush_in   = 1'b0;
        d.flush_key  = 1'b0;
        d.flush_all  = 1'b0;
        d.fifo_wr    = 1'b0;

        if (reg_wr_i) begin
            unique case (reg_addr_i)
                OFS_CTRL_PRI: begin
                    d.ctrl = reg_wdata_i & MASK_CTRL_PRI;
                end
                OFS_CTRL_SEC: begin
                    d.ctrl2 = reg_wdata_i & MASK_CTRL_SEC;
                end
                OFS_DUMMY: begin
                    d.dummy = reg_wdata_i & MASK_DUMMY;
                end
                OFS_SW_MASK: begin
                    d.sw_mask = reg_wdata_i;
                end
                OFS_HASH_CTRL: begin
                    d.hash = (reg_wdata_i & MASK_HASH_CTRL) | RST_HASH_CTRL & 32'h0;
                    // RULE22 - stop ends auto mode
                    if (reg_wdata_i[H_STOP]) begin
                        d.hash[H_AUTO] = 1'b0;
                    end
                end
                OFS_HASH_FIFO: begin
                    // RULE12 - swapped hash FIFO write
                    d.fifo_wr    = 1'b1;
                    d.fifo_wdata = swap32(reg_wdata_i, q.ctrl2[S_BSWAP]);
                end
                default: begin
                end
            endcase
        end

        // RULE11 - start on one only
        d.start = start_ok;
        // RULE17 - flush command pulses
        d.flush_all = wr_sec && reg_wdata_i[S_FLUSH];
        d.flush_key = wr_sec && reg_wdata_i[S_KFL];
        d.flush_in  = wr_sec && reg_wdata_i[S_DFL];

        // RULE23 - busy until done or full flush
        if (start_ok) begin
            d.busy = 1'b1;
        end else if (kernel_done_i || d.flush_all) begin
            d.busy = 1'b0;
        end

        // RULE24 - calculation counter
        if (count_ok) begin
            d.count = q.count + 16'h0001;
        end

        // RULE14 - seed stepping
        if (reg_wr_i && (reg_addr_i == OFS_SEED)) begin
            d.seed = reg_wdata_i;
        end else if (bank_access_i ||
                     (q.ctrl2[S_MSTEP] && reg_rd_i && (reg_addr_i == OFS_SEED))) begin
            d.seed = q.seed + 32'h0000_0001;
        end

        // RULE25 - command bits read zero
        if (reg_rd_i) begin
            unique case (reg_addr_i)
                OFS_CTRL_PRI:  d.rdata = q.ctrl;
                OFS_CTRL_SEC:  d.rdata = q.ctrl2;
                OFS_DUMMY:     d.rdata = q.dummy;
                OFS_SW_MASK:   d.rdata = q.sw_mask;
                OFS_SEED:      d.rdata = q.seed;
                OFS_HASH_CTRL: d.rdata = q.hash;
                OFS_HASH_FIFO: d.rdata = swap32(hash_fifo_rdata_i, q.ctrl2[S_BSWAP]);
                OFS_BUILD_CFG: d.rdata = build_cfg;
                default:       d.rdata = 32'h0000_0000;
            endcase
        end

        // RULE6 - kernel input mux
        case (q.ctrl[P_INPUT_MUX_SELECT +: 4])
            4'h0, 4'h1, 4'h2, 4'h3: begin
                d.kin = input_bank_i[bank_idx(q.ctrl[P_INPUT_MUX_SELECT +: 2])];
            end
            4'h4, 4'h5, 4'h6, 4'h7: begin
                d.kin = input_bank_i[bank_idx(q.ctrl[P_INPUT_MUX_SELECT +: 2])] ^ output_bank_i;
            end
            4'h8: begin
                d.kin = output_bank_i;
            end
            default: begin
                d.kin = input_bank_i[0];
            end
        endcase

        // RULE5 - output XOR mux
        case (q.ctrl[P_OSEL +: 3])
            3'h1, 3'h2, 3'h3, 3'h4: begin
                d.kout = kernel_result_i ^
                         input_bank_i[bank_idx(2'(q.ctrl[P_OSEL +: 3] - 3'h1))];
            end
            default: begin
                d.kout = kernel_result_i;
            end
        endcase

        if (rst_i) begin
            d      = '0;
            d.hash = RST_HASH_CTRL;
        end
    end

    always_ff @(posedge clk_i) begin
        q <= d;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    always_comb begin
        cipher_cfg_o = '0;
        cipher_cfg_o.operation_select     = op_eff;
        // RULE8 - triple key count
        cipher_cfg_o.triple_key_count_sel = q.ctrl[P_TKEY];
        // RULE1 - key base index
        cipher_cfg_o.input_key_base       = q.ctrl[P_KBASE +: 5];
        // RULE9 - reserved length as 128
        cipher_cfg_o.aes_key_length       = (q.ctrl[P_KLEN +: 2] == 2'h2) ? 2'h2
                                                                          : 2'h0;
        // RULE10 - cipher direction
        cipher_cfg_o.cipher_direction     = q.ctrl[P_DIR];
        // RULE3 - kernel enables
        cipher_cfg_o.aes_enable           = q.ctrl[P_AESEN] & HAS_AES;
        cipher_cfg_o.des_enable           = q.ctrl[P_DESEN] & HAS_DES;
        cipher_cfg_o.field_mult_enable    = q.ctrl[P_GFEN] & HAS_GFMUL;
        // RULE2 - generator only if built
        cipher_cfg_o.random_gen_enable    = q.ctrl[P_PRNG] & HAS_PRNG;
        // RULE4 - output update timing
        cipher_cfg_o.output_update_timing = q.ctrl[P_OUPD +: 2];
        // RULE13 - result placement
        cipher_cfg_o.result_to_key        = q.ctrl2[S_RKEY];
        cipher_cfg_o.result_key_base      = q.ctrl2[S_RBASE +: 5];
        // RULE18 - dummy settings
        cipher_cfg_o.aes_dummy_setting    = q.dummy[25:16];
        cipher_cfg_o.des_dummy_setting    = q.dummy[9:0];

        bank_cfg_o = '0;
        // RULE16 - write side controls
        bank_cfg_o.flush_write_mode       = q.ctrl2[S_FLWR];
        bank_cfg_o.xor_on_write           = q.ctrl2[S_XOR_ON_WRITE];
        bank_cfg_o.increment_on_write     = q.ctrl2[S_INCREMENT_ON_WRITE];
        // RULE15 - carry select
        bank_cfg_o.increment_carry_select = q.ctrl2[S_CIN];
        // RULE12 - bank byte order
        bank_cfg_o.bank_byte_swap         = q.ctrl2[S_BSWAP];
        // RULE14 - mask source
        bank_cfg_o.register_mask_enable   = q.ctrl2[S_MEN];
        bank_cfg_o.mask_value             = !q.ctrl2[S_MEN] ? 32'h0000_0000 :
                                            q.ctrl2[S_MSW] ? q.sw_mask : hw_mask_i;

        hash_cfg_o = '0;
        // RULE22 - hash enable and mode
        hash_cfg_o.hash_unit_enable       = q.hash[H_EN];
        hash_cfg_o.hash_auto_select       = q.hash[H_AUTO];
        // RULE21 - hash size mapping
        hash_cfg_o.hash_length_sel        = SHA256_ONLY ? {1'b0, q.hash[H_SIZE]}
                                                        : q.hash[H_SIZE +: 2];
        // RULE19 - init and reload
        hash_cfg_o.hash_auto_init         = !q.hash[H_NOINI];
        hash_cfg_o.hash_value_reload      = q.hash[H_RLD];
        hash_cfg_o.fifo_low_limit         = q.hash[H_LOW +: 4];
        hash_cfg_o.fifo_high_limit        = q.hash[H_HIGH +: 4];
    end

    assign reg_rdata_o        = q.rdata;
    assign kernel_input_o     = q.kin;
    assign output_data_o      = q.kout;
    assign start_o            = q.start;
    assign busy_o             = q.busy;
    assign calc_count_o       = q.count;
    assign input_bank_clear_o = q.flush_in;
    assign key_bank_clear_o   = q.flush_key;
    assign full_flush_o       = q.flush_all;
    assign hash_fifo_wr_o     = q.fifo_wr;
    assign hash_fifo_wdata_o  = q.fifo_wdata;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_START_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        start_ok |=> start_o && busy_o)
        else $error("start write did not pulse start");

    AST_START_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // RULE11
        (wr_pri && !reg_wdata_i[P_START]) |=> !start_o)
        else $error("zero start bit started an operation");

    AST_BUSY_HOLD: assert property (@(posedge clk_i) disable iff (rst_i) // RULE23
        (busy_o && !kernel_done_i && !full_flush_o && !d.flush_all) |=> busy_o)
        else $error("busy dropped before done");

    AST_COUNT_INC: assert property (@(posedge clk_i) disable iff (rst_i) // RULE24
        count_ok |=> calc_count_o == $past(calc_count_o) + 16'h0001)
        else $error("counter did not step on start");

    AST_HASH_NOCOUNT: assert property (@(posedge clk_i) disable iff (rst_i) // RULE20
        (start_ok && op_wr == OP_SHA && !q.hash[H_CNT]) |=> $stable(calc_count_o))
        else $error("hash start counted with count disabled");

    AST_FLUSH_PULSE: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
        (wr_sec && reg_wdata_i[S_FLUSH]) |=> full_flush_o ##1 (!full_flush_o || $past(wr_sec)))
        else $error("full flush not a one-cycle pulse");

    AST_CMD_READ_ZERO: assert property (@(posedge clk_i) disable iff (rst_i) // RULE25
        (reg_rd_i && (reg_addr_i == OFS_CTRL_PRI || reg_addr_i == OFS_CTRL_SEC))
        |=> reg_rdata_o[2:0] == 3'h0 || (reg_rdata_o[0] == 1'b0 && $past(reg_addr_i) == OFS_CTRL_PRI))
        else $error("command bit read back as one");

    AST_KEYLEN: assert property (@(posedge clk_i) disable iff (rst_i) // RULE9
        cipher_cfg_o.aes_key_length != 2'h3 && cipher_cfg_o.aes_key_length[0] == 1'b0)
        else $error("key length code not 128 or 256");

    AST_IN_OUTBANK: assert property (@(posedge clk_i) disable iff (rst_i) // RULE6
        (q.ctrl[P_INPUT_MUX_SELECT +: 4] == 4'h8) |=> kernel_input_o == $past(output_bank_i))
        else $error("input select 8 did not pass output bank");

    AST_OUT_RAW: assert property (@(posedge clk_i) disable iff (rst_i) // RULE5
        (q.ctrl[P_OSEL +: 3] > 3'h4 || q.ctrl[P_OSEL +: 3] == 3'h0)
        |=> output_data_o == $past(kernel_result_i))
        else $error("raw output select not raw");

    AST_SEED_STEP: assert property (@(posedge clk_i) disable iff (rst_i) // RULE14
        (bank_access_i && !(reg_wr_i && reg_addr_i == OFS_SEED))
        |=> q.seed == $past(q.seed) + 32'h0000_0001)
        else $error("seed did not step on bank access");

    AST_HASH_STOP: assert property (@(posedge clk_i) disable iff (rst_i) // RULE22
        (reg_wr_i && reg_addr_i == OFS_HASH_CTRL && reg_wdata_i[H_STOP])
        |=> !q.hash[H_AUTO])
        else $error("stop bit left auto mode on");

    AST_KEY_FLUSH: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
        (wr_sec && reg_wdata_i[S_KFL])
        |=> key_bank_clear_o)
        else $error("key flush not pulsed");

    AST_IN_FLUSH: assert property (@(posedge clk_i) disable iff (rst_i) // RULE17
        (wr_sec && reg_wdata_i[S_DFL])
        |=> input_bank_clear_o)
        else $error("input flush not pulsed");

endmodule // crypto_engine_control

`default_nettype wire
